/* File: src/swl_top.sv */
module swl_top #(
  parameter int TICK_CYCLES_P = swl_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Input terminals
  input wire logic lenPulse,
  input wire logic cntPulse,
  input wire logic fastPulseInput,
  input wire logic lenClear,
  input wire logic cntClear,
  // Output terminals
  output logic lenReached,
  output logic setCntReached,
  output logic desCntReached,
  output logic [15:0] swingFreq,
  output logic irq
);
  import swl_pkg::*;

  logic [2:0] ctrl_q;
  logic [15:0] center_q, maxFreq_q, upper_q, lower_q;
  logic [15:0] swingAmp_q, jumpAmp_q, cycle_q, riseCoef_q;
  logic [15:0] setLen_q, ppm_q, setCnt_q, desCnt_q;
  logic [2:0] irqStat_q, irqMask_q, irqStat_d, flagPrev_q, evt;
  logic [31:0] rdData;
  logic wrEn;
  logic [15:0] wd16;

  logic lenSrc, cntSrc, lenPrev_q, cntPrev_q, lenEdge, cntEdge;
  logic [27:0] pulses_q;
  logic [15:0] lenAct_q, count_q;
  logic lenBusy, lenDone, lenDiscard_q;
  logic [31:0] lenQuot;

  logic [15:0] ampW_q, jump_q, riseT_q, fallT_q, phase_q, phaseNext, segLen;
  logic [31:0] tickCnt_q;
  logic swTick, swingOn, swBusy, swDone, swDivRise_q, swDivOk_q;
  logic [16:0] span, stepQ;
  logic [31:0] swQuot;
  logic signed [18:0] off_q;
  swl_swing_t swState_q;

  function automatic logic [15:0] clampF(input logic signed [18:0] v, input logic [15:0] hi,
                                         input logic [15:0] lo);
    if (v > $signed({3'b000, hi})) return hi;
    else if (v < $signed({3'b000, lo})) return lo;
    else return v[15:0];
  endfunction

  // One wait state per access, answer on the second cycle
  assign wrEn = write && !waitrequest;
  assign wd16 = writedata[15:0];

  always_ff @(posedge ref_clk) begin
    if (!rstn) waitrequest <= 1'b1;
    else waitrequest <= !((read || write) && waitrequest);
  end

  always_comb begin
    rdData = 32'h00000000;
    case (address)
      REG_CTRL: rdData = {29'h0, ctrl_q};
      REG_CENTER: rdData = {16'h0, center_q};
      REG_MAXF: rdData = {16'h0, maxFreq_q};
      REG_UPPER: rdData = {16'h0, upper_q};
      REG_LOWER: rdData = {16'h0, lower_q};
      REG_SWING_AMP: rdData = {16'h0, swingAmp_q};
      REG_JUMP_AMP: rdData = {16'h0, jumpAmp_q};
      REG_CYCLE: rdData = {16'h0, cycle_q};
      REG_RISE_COEF: rdData = {16'h0, riseCoef_q};
      REG_SET_LEN: rdData = {16'h0, setLen_q};
      REG_ACT_LEN: rdData = {16'h0, lenAct_q};
      REG_PULSE_PER_M: rdData = {16'h0, ppm_q};
      REG_SET_CNT: rdData = {16'h0, setCnt_q};
      REG_DES_CNT: rdData = {16'h0, desCnt_q};
      REG_COUNT: rdData = {16'h0, count_q};
      REG_OUT_FREQ: rdData = {16'h0, swingFreq};
      REG_IRQ_STAT: rdData = {29'h0, irqStat_q};
      REG_IRQ_MASK: rdData = {29'h0, irqMask_q};
      REG_FLAGS: rdData = {29'h0, desCntReached, setCntReached, lenReached};
      default: rdData = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) readdata <= 32'h00000000;
    else if (read && waitrequest) readdata <= rdData;
  end

  // Out-of-range settings saturate so the arithmetic stays bounded
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_q <= RST_CTRL;
      center_q <= RST_CENTER;
      maxFreq_q <= RST_MAXF;
      upper_q <= RST_UPPER;
      lower_q <= RST_LOWER;
      swingAmp_q <= RST_SWING_AMP;
      jumpAmp_q <= RST_JUMP_AMP;
      cycle_q <= RST_CYCLE;
      riseCoef_q <= RST_RISE_COEF;
      setLen_q <= RST_SET_LEN;
      ppm_q <= RST_PULSE_PER_M;
      setCnt_q <= RST_SET_CNT;
      desCnt_q <= RST_DES_CNT;
      irqMask_q <= 3'h0;
    end else if (wrEn) begin
      case (address)
        REG_CTRL: ctrl_q <= writedata[2:0];
        REG_CENTER: center_q <= wd16;
        REG_MAXF: maxFreq_q <= wd16;
        REG_UPPER: upper_q <= wd16;
        REG_LOWER: lower_q <= wd16;
        REG_SWING_AMP: swingAmp_q <= sat16(wd16, SWING_AMP_MAX);
        REG_JUMP_AMP: jumpAmp_q <= sat16(wd16, JUMP_AMP_MAX);
        REG_CYCLE: cycle_q <= sat16(wd16, CYCLE_MAX);
        REG_RISE_COEF: riseCoef_q <= sat16(wd16, PERMILLE);
        REG_SET_LEN: setLen_q <= wd16;
        REG_PULSE_PER_M: ppm_q <= (wd16 == 16'h0000) ? 16'h0001 : wd16;
        REG_SET_CNT: setCnt_q <= (wd16 == 16'h0000) ? 16'h0001 : wd16;
        REG_DES_CNT: desCnt_q <= (wd16 == 16'h0000) ? 16'h0001 : wd16;
        REG_IRQ_MASK: irqMask_q <= writedata[2:0];
        default: ;
      endcase
    end
  end

  // Flag rises feed the sticky status; set wins over a write-one clear
  assign evt = {desCntReached, setCntReached, lenReached} & ~flagPrev_q;

  always_comb begin
    irqStat_d = irqStat_q;
    if (wrEn && address == REG_IRQ_STAT) irqStat_d = irqStat_d & ~writedata[2:0];
    irqStat_d = irqStat_d | evt;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flagPrev_q <= 3'h0;
      irqStat_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      flagPrev_q <= {desCntReached, setCntReached, lenReached};
      irqStat_q <= irqStat_d;
      irq <= |(irqStat_d & irqMask_q);
    end
  end

  assign lenSrc = ctrl_q[CTRL_LEN_FAST_BIT] ? fastPulseInput : lenPulse;
  assign cntSrc = ctrl_q[CTRL_CNT_FAST_BIT] ? fastPulseInput : cntPulse;
  assign lenEdge = lenSrc && !lenPrev_q;
  assign cntEdge = cntSrc && !cntPrev_q;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lenPrev_q <= 1'b0;
      cntPrev_q <= 1'b0;
    end else begin
      lenPrev_q <= lenSrc;
      cntPrev_q <= cntSrc;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) pulses_q <= 28'h0;
    else if (lenClear) pulses_q <= 28'h0;
    else if (lenEdge && pulses_q != PULSE_MAX) pulses_q <= pulses_q + 28'h1;
  end

  swl_divider lenDiv (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(!lenBusy),
    .dividend(32'(pulses_q) * LEN_SCALE),
    .divisor(ppm_q),
    .busy(lenBusy),
    .done(lenDone),
    .quotient(lenQuot)
  );

  // A division in flight at a clear would bring back the old length
  // tenths of a metre from pulse count
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      lenAct_q <= 16'h0000;
      lenDiscard_q <= 1'b0;
    end else if (lenClear) begin
      lenAct_q <= 16'h0000;
      lenDiscard_q <= 1'b1;
    end else begin
      if (lenDone && !lenDiscard_q) lenAct_q <= (lenQuot > 32'h0000FFFF) ? 16'hFFFF : lenQuot[15:0];
      if (!lenBusy) lenDiscard_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) lenReached <= 1'b0;
    else if (lenClear) lenReached <= 1'b0;
    else if (lenAct_q > setLen_q) lenReached <= 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) count_q <= 16'h0000;
    else if (cntClear) count_q <= 16'h0000;
    else if (cntEdge && count_q < setCnt_q) count_q <= count_q + 16'h0001;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      setCntReached <= 1'b0;
      desCntReached <= 1'b0;
    end else if (cntClear) begin
      setCntReached <= 1'b0;
      desCntReached <= 1'b0;
    end else begin
      if (count_q >= setCnt_q) setCntReached <= 1'b1;
      if (count_q >= desCnt_q) desCntReached <= 1'b1;
    end
  end

  // base from mode; jump from amplitude
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ampW_q <= 16'h0000;
      jump_q <= 16'h0000;
      riseT_q <= 16'h0000;
      fallT_q <= 16'h0000;
    end else begin
      ampW_q <= pctOf(ctrl_q[CTRL_MODE_BIT] ? maxFreq_q : center_q, swingAmp_q);
      jump_q <= pctOf(ampW_q, jumpAmp_q);
      riseT_q <= pctOf(cycle_q, riseCoef_q);
      fallT_q <= cycle_q - pctOf(cycle_q, riseCoef_q);
    end
  end

  assign swTick = tickCnt_q == 32'(TICK_CYCLES_P - 1);
  assign swingOn = swingAmp_q != 16'h0000 && cycle_q != 16'h0000;
  assign phaseNext = phase_q + 16'h0001;
  assign segLen = (swState_q == SW_RISE) ? riseT_q : fallT_q;

  always_ff @(posedge ref_clk) begin
    if (!rstn || swTick) tickCnt_q <= 32'h00000000;
    else tickCnt_q <= tickCnt_q + 32'h00000001;
  end

  // rise then fall share of the period
  always_ff @(posedge ref_clk) begin
    if (!rstn || !swingOn) begin
      swState_q <= SW_IDLE;
      phase_q <= 16'h0000;
    end else begin
      unique case (swState_q)
        SW_IDLE: begin
          swState_q <= SW_RISE;
          phase_q <= 16'h0000;
        end
        SW_RISE: begin
          if (riseT_q == 16'h0000 || (swTick && phaseNext >= riseT_q)) begin
            swState_q <= SW_FALL;
            phase_q <= 16'h0000;
          end else if (swTick) phase_q <= phaseNext;
        end
        SW_FALL: begin
          if (fallT_q == 16'h0000 || (swTick && phaseNext >= fallT_q)) begin
            swState_q <= SW_RISE;
            phase_q <= 16'h0000;
          end else if (swTick) phase_q <= phaseNext;
        end
      endcase
    end
  end

  // Ramp spans twice the amplitude less one jump, the jump happens at the turn
  assign span = {ampW_q, 1'b0} - {1'b0, jump_q};
  // Last phase lands on the turn point; a one-tick ramp goes straight there
  assign stepQ = (swQuot > 32'(span)) ? span : swQuot[16:0];

  swl_divider swDiv (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(!swBusy),
    .dividend(32'(span) * 32'(phase_q)),
    .divisor(segLen - 16'h0001),
    .busy(swBusy),
    .done(swDone),
    .quotient(swQuot)
  );

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      swDivRise_q <= 1'b1;
      swDivOk_q <= 1'b0;
      off_q <= 19'sh0;
    end else begin
      if (!swBusy) begin
        swDivRise_q <= swState_q == SW_RISE;
        swDivOk_q <= swState_q != SW_IDLE && segLen != 16'h0000;
      end
      if (swDone && swDivOk_q) begin
        if (swDivRise_q)
          off_q <= $signed({3'b000, jump_q}) - $signed({3'b000, ampW_q}) + $signed({2'b00, stepQ});
        else
          off_q <= $signed({3'b000, ampW_q}) - $signed({3'b000, jump_q}) - $signed({2'b00, stepQ});
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) swingFreq <= 16'h0000;
    else if (swState_q == SW_IDLE) swingFreq <= clampF($signed({3'b000, center_q}), upper_q, lower_q);
    else swingFreq <= clampF($signed({3'b000, center_q}) + off_q, upper_q, lower_q);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_amp_base: assert property (ctrl_q[CTRL_MODE_BIT] |=>
    ampW_q == pctOf($past(maxFreq_q), $past(swingAmp_q))) else $error("amplitude base wrong");
  a_swing_off: assert property ((swingAmp_q == 16'h0000) |=> swState_q == SW_IDLE ##1
    swingFreq == clampF($signed({3'b000, $past(center_q)}), $past(upper_q), $past(lower_q)))
    else $error("swing not disabled");
  a_amp_scale: assert property (!ctrl_q[CTRL_MODE_BIT] |=>
    ampW_q == pctOf($past(center_q), $past(swingAmp_q))) else $error("amplitude scale wrong");
  a_jump_step: assert property (1'b1 |=> jump_q == pctOf($past(ampW_q), $past(jumpAmp_q)))
    else $error("jump step wrong");
  a_freq_clamp: assert property ((lower_q <= upper_q && $stable(lower_q) && $stable(upper_q)) |->
    swingFreq <= upper_q && swingFreq >= lower_q) else $error("output outside limits");
  a_cycle_wrap: assert property ((swingOn && swState_q == SW_FALL && fallT_q != 16'h0000 && swTick
    && phaseNext >= fallT_q && $stable(swingAmp_q) && $stable(cycle_q)) |=> swState_q == SW_RISE && phase_q == 16'h0000)
    else $error("period did not wrap");
  a_rise_len: assert property ((swingOn && swState_q == SW_RISE && riseT_q != 16'h0000 && swTick
    && phaseNext >= riseT_q && $stable(swingAmp_q) && $stable(cycle_q)) |=> swState_q == SW_FALL)
    else $error("rise ramp length wrong");
  a_len_scale: assert property ((lenDone && !lenDiscard_q && !lenClear && lenQuot < 32'h00010000) |=>
    lenAct_q == 16'($past(lenQuot))) else $error("length not updated");
  a_len_flag: assert property ((lenAct_q > setLen_q && !lenClear) |=> lenReached)
    else $error("length reached missing");
  a_len_clear: assert property (lenClear |=> lenAct_q == 16'h0000 && pulses_q == 28'h0 && !lenReached)
    else $error("length not cleared");
  a_cnt_halt: assert property ((count_q >= setCnt_q && !cntClear) |=> $stable(count_q) && setCntReached)
    else $error("counter did not halt");
  a_des_flag: assert property ((count_q >= desCnt_q && !cntClear) |=> desCntReached)
    else $error("designated flag missing");
  a_flag_hold: assert property ((setCntReached && !cntClear) |=> setCntReached)
    else $error("count flag dropped");

  c_set_reach: cover property ($rose(setCntReached));
  c_des_first: cover property ($rose(desCntReached) ##[1:50] $rose(setCntReached));
  c_len_reach: cover property ($rose(lenReached));
  c_swing_turn: cover property (swState_q == SW_RISE ##1 swState_q == SW_FALL);
endmodule // swl_top

/* File: common/swl_pkg.sv */
// Behaviour
// - Mode picks centre or maximum as base
// - Zero amplitude disables swing, centre out
// - Amplitude is base times percentage
// - Jump step is amplitude times jump percentage
// - Output clamped between lower and upper limits
// - Triangle period programmable, ten seconds default
// - Rise share set by coefficient, default half
// - Length is ten times pulses divided by pulses-per-metre
// - Length reached once length exceeds set
// - Length clear input zeroes accumulated length
// - Set count reached flags and halts counting
// - Designated count flags, counting continues
package swl_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int SWING_TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * SWING_TICK_MS;
  localparam int DIV_CYCLES = 33;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CENTER = 8'h04;
  localparam logic [7:0] REG_MAXF = 8'h08;
  localparam logic [7:0] REG_UPPER = 8'h0C;
  localparam logic [7:0] REG_LOWER = 8'h10;
  localparam logic [7:0] REG_SWING_AMP = 8'h14;
  localparam logic [7:0] REG_JUMP_AMP = 8'h18;
  localparam logic [7:0] REG_CYCLE = 8'h1C;
  localparam logic [7:0] REG_RISE_COEF = 8'h20;
  localparam logic [7:0] REG_SET_LEN = 8'h24;
  localparam logic [7:0] REG_ACT_LEN = 8'h28;
  localparam logic [7:0] REG_PULSE_PER_M = 8'h2C;
  localparam logic [7:0] REG_SET_CNT = 8'h30;
  localparam logic [7:0] REG_DES_CNT = 8'h34;
  localparam logic [7:0] REG_COUNT = 8'h38;
  localparam logic [7:0] REG_OUT_FREQ = 8'h3C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h40;
  localparam logic [7:0] REG_IRQ_MASK = 8'h44;
  localparam logic [7:0] REG_FLAGS = 8'h48;

  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_LEN_FAST_BIT = 1;
  localparam int CTRL_CNT_FAST_BIT = 2;
  localparam int IRQ_LEN_BIT = 0;
  localparam int IRQ_SET_BIT = 1;
  localparam int IRQ_DES_BIT = 2;

  localparam logic [15:0] PERMILLE = 16'h03E8;
  localparam logic [15:0] SWING_AMP_MAX = 16'h03E8;
  localparam logic [15:0] JUMP_AMP_MAX = 16'h01F4;
  localparam logic [15:0] CYCLE_MAX = 16'h7530;
  localparam logic [31:0] LEN_SCALE = 32'h0000000A;
  localparam logic [27:0] PULSE_MAX = 28'hFFFFFFF;

  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [15:0] RST_CENTER = 16'h1388;
  localparam logic [15:0] RST_MAXF = 16'h1388;
  localparam logic [15:0] RST_UPPER = 16'h1388;
  localparam logic [15:0] RST_LOWER = 16'h0000;
  localparam logic [15:0] RST_SWING_AMP = 16'h0000;
  localparam logic [15:0] RST_JUMP_AMP = 16'h0000;
  localparam logic [15:0] RST_CYCLE = 16'h0064;
  localparam logic [15:0] RST_RISE_COEF = 16'h01F4;
  localparam logic [15:0] RST_SET_LEN = 16'h03E8;
  localparam logic [15:0] RST_PULSE_PER_M = 16'h03E8;
  localparam logic [15:0] RST_SET_CNT = 16'h03E8;
  localparam logic [15:0] RST_DES_CNT = 16'h03E8;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_RISE = 3'b010,
    SW_FALL = 3'b100
  } swl_swing_t;

  // Share of a value in tenths of a percent
  function automatic logic [15:0] pctOf(input logic [15:0] base, input logic [15:0] pm);
    logic [31:0] prod;
    prod = 32'(base) * 32'(pm);
    return 16'(prod / 32'(PERMILLE));
  endfunction

  function automatic logic [15:0] sat16(input logic [15:0] v, input logic [15:0] lim);
    return (v > lim) ? lim : v;
  endfunction
endpackage

/* File: src/swl_divider.sv */
module swl_divider (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Request
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [15:0] divisor,
  // Answer
  output logic busy,
  output logic done,
  output logic [31:0] quotient
);
  import swl_pkg::*;

  logic [15:0] rem_q;
  logic [31:0] work_q;
  logic [15:0] div_q;
  logic [5:0] cnt_q;
  logic [16:0] shifted;
  logic ge;
  logic [15:0] remNext;
  logic [31:0] workNext;

  // Zero divisor falls out as all ones
  always_comb begin
    shifted = {rem_q, work_q[31]};
    ge = shifted >= {1'b0, div_q};
    remNext = ge ? 16'(shifted - {1'b0, div_q}) : shifted[15:0];
    workNext = {work_q[30:0], ge};
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_q <= 6'h00;
      rem_q <= 16'h0000;
      work_q <= 32'h00000000;
      div_q <= 16'h0000;
      quotient <= 32'h00000000;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        rem_q <= 16'h0000;
        work_q <= dividend;
        div_q <= divisor;
        cnt_q <= 6'h20;
      end else if (busy) begin
        rem_q <= remNext;
        work_q <= workNext;
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          quotient <= workNext;
        end
      end
    end
  end

  a_div_latency: assert property (@(posedge ref_clk) disable iff (!rstn)
    (start && !busy) |-> ##33 done) else $error("divider latency wrong");
endmodule // swl_divider

/* File: dv/swl_term_model.sv */
module swl_term_model (
  // Clock
  input wire logic ref_clk,
  // Terminals
  output logic lenPulse,
  output logic cntPulse,
  output logic fastPulseInput,
  output logic lenClear,
  output logic cntClear
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {lenPulse, cntPulse, fastPulseInput, lenClear, cntClear} = 5'h00;
  end

  task automatic pulses(input int sel, input int n, input int gap);
    repeat (n) begin
      @(posedge ref_clk);
      case (sel)
        0: lenPulse <= 1'h1;
        1: cntPulse <= 1'h1;
        default: fastPulseInput <= 1'h1;
      endcase
      @(posedge ref_clk);
      {lenPulse, cntPulse, fastPulseInput} <= 3'h0;
      repeat (gap - 1) @(posedge ref_clk);
    end
  endtask

  task automatic clear(input bit len);
    @(posedge ref_clk);
    if (len) lenClear <= 1'h1;
    else cntClear <= 1'h1;
    repeat (2) @(posedge ref_clk);
    {lenClear, cntClear} <= 2'h0;
  endtask
endmodule // swl_term_model

/* File: dv/swing_length_count_tb.sv */
module swing_length_count_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import swl_pkg::*;
  localparam int TK = 40;
  logic ref_clk = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] address = 8'h00;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, lenPulse, cntPulse, fastPulseInput, lenClear, cntClear;
  logic lenReached, setCntReached, desCntReached, irq;
  logic [15:0] swingFreq;
  logic [15:0] p, s, d, act;
  int err_total = 0;
  int check_count = 0;
  int tot;
  integer seed = 32'h9A74FB97;
  logic [7:0] ra [18] = '{REG_CTRL, REG_CENTER, REG_MAXF, REG_UPPER, REG_LOWER, REG_SWING_AMP, REG_JUMP_AMP,
    REG_CYCLE, REG_RISE_COEF, REG_SET_LEN, REG_PULSE_PER_M, REG_SET_CNT, REG_DES_CNT, REG_ACT_LEN, REG_COUNT,
    REG_OUT_FREQ, REG_IRQ_MASK, 8'hFC};
  logic [15:0] rv [18] = '{16'h0, 16'h1388, 16'h1388, 16'h1388, 16'h0, 16'h0, 16'h0, 16'h64, 16'h1F4, 16'h3E8,
    16'h3E8, 16'h3E8, 16'h3E8, 16'h0, 16'h0, 16'h1388, 16'h0, 16'h0};

  always #20 ref_clk = ~ref_clk;

  swl_top #(.TICK_CYCLES_P(TK)) uut (.ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .lenPulse(lenPulse),
    .cntPulse(cntPulse), .fastPulseInput(fastPulseInput), .lenClear(lenClear), .cntClear(cntClear),
    .lenReached(lenReached), .setCntReached(setCntReached), .desCntReached(desCntReached),
    .swingFreq(swingFreq), .irq(irq));
  swl_term_model term (.ref_clk(ref_clk), .lenPulse(lenPulse), .cntPulse(cntPulse),
    .fastPulseInput(fastPulseInput), .lenClear(lenClear), .cntClear(cntClear));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  // Request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dt, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    address <= a;
    writedata <= dt;
    if (wr) write <= 1'h1;
    else read <= 1'h1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'h0 && n < 20);
    q = readdata;
    chk(waitrequest, 32'h0, "bus answer");
    write <= 1'h0;
    read <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    logic [31:0] q;
    bus(1'h1, a, dt, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, exp, what);
  endtask

  function automatic logic [15:0] pm(input logic [15:0] b, input logic [15:0] pc);
    return 16'((32'(b) * 32'(pc)) / 32'h3E8);
  endfunction

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic swing_run(input logic mode, input logic [15:0] c, mf, amp, jmp, up, lo);
    logic [15:0] aw, j, eMax, eMin, hi, lw, prev, aft;
    int tTop, tBot, per, rise;
    aw = pm(mode ? mf : c, amp);
    j = pm(aw, jmp);
    eMax = (c + aw > up) ? up : c + aw;
    eMin = (c < lo + aw) ? lo : c - aw;
    wr(REG_UPPER, 32'(up));
    wr(REG_LOWER, 32'(lo));
    wr(REG_CENTER, 32'(c));
    wr(REG_MAXF, 32'(mf));
    wr(REG_CTRL, 32'(mode));
    wr(REG_JUMP_AMP, 32'(jmp));
    wr(REG_CYCLE, 32'hA);
    wr(REG_RISE_COEF, 32'h12C);
    wr(REG_SWING_AMP, 32'(amp));
    repeat (600) @(posedge ref_clk);
    hi = 16'h0;
    lw = 16'hFFFF;
    prev = swingFreq;
    aft = 16'h0;
    tTop = -1;
    tBot = -1;
    per = 0;
    rise = 0;
    for (int k = 0; k < 2000; k++) begin
      @(posedge ref_clk);
      if (swingFreq > hi) hi = swingFreq;
      if (swingFreq < lw) lw = swingFreq;
      if (swingFreq == eMax && prev != eMax) begin
        if (tTop >= 0) per = k - tTop;
        if (tBot >= 0) rise = k - tBot;
        tTop = k;
      end
      if (swingFreq == eMin && prev != eMin) tBot = k;
      if (prev == eMax && swingFreq != eMax && aft == 16'h0) aft = swingFreq;
      prev = swingFreq;
    end
    chk(hi, eMax, "swing top");
    chk(lw, eMin, "swing bottom");
    chk(per >= 9 * TK && per <= 11 * TK, 1'h1, "period");
    if (c + aw < up) chk(aft, c + aw - j, "jump");
    if (c + aw < up && c - aw > lo) chk(rise >= 2 * TK && rise <= 4 * TK, 1'h1, "rise");
    done("swing");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Whole run needs well under this many cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    $display("BAD t=%0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'h1;
    @(posedge ref_clk);
    for (int i = 0; i < 18; i++) rdchk(ra[i], 32'(rv[i]), "reset value");
    done("registers");
    swing_run(1'h0, 16'(3000 + $unsigned($random(seed)) % 2000), 16'h1388,
      16'(100 + $unsigned($random(seed)) % 300), 16'(50 + $unsigned($random(seed)) % 451), 16'h1F40, 16'h0);
    swing_run(1'h1, 16'h0FA0, 16'h1770, 16'h00FA, 16'h00C8, 16'h1F40, 16'h0);
    swing_run(1'h0, 16'h1388, 16'h1388, 16'h01F4, 16'h0064, 16'h1770, 16'h0DAC);
    wr(REG_SWING_AMP, 32'h0);
    repeat (5) @(posedge ref_clk);
    chk(swingFreq, 16'h1388, "no swing");
    done("swing off");
    for (int r = 0; r < 2; r++) begin
      p = (r == 0) ? 16'h0028 : 16'(20 + $unsigned($random(seed)) % 41);
      wr(REG_PULSE_PER_M, 32'(p));
      wr(REG_SET_LEN, 32'h3);
      wr(REG_CTRL, 32'h0);
      tot = 0;
      for (int i = 0; i < 6; i++) begin
        if (i == 3) wr(REG_CTRL, 32'h2);
        term.pulses(i < 3 ? 0 : 2, 4, 1 + i);
        tot += 4;
        repeat (80) @(posedge ref_clk);
        act = 16'((tot * 10) / p);
        rdchk(REG_ACT_LEN, 32'(act), "length");
        chk(lenReached, act > 16'h3, "length flag");
      end
      if (r == 0) rdchk(REG_IRQ_STAT, 32'h1, "length status");
      if (r == 0) chk(irq, 32'h0, "irq masked");
      term.clear(1'h1);
      repeat (80) @(posedge ref_clk);
      rdchk(REG_ACT_LEN, 32'h0, "length cleared");
      chk(lenReached, 32'h0, "length flag cleared");
      if (r == 0) begin
        wr(REG_IRQ_MASK, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk(irq, 32'h1, "irq raised");
        wr(REG_IRQ_STAT, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk(irq, 32'h0, "irq cleared");
      end
    end
    done("length");
    for (int r = 0; r < 2; r++) begin
      s = 16'(5 + $unsigned($random(seed)) % 8);
      d = (r == 0) ? s : 16'(1 + $unsigned($random(seed)) % s);
      wr(REG_SET_CNT, 32'(s));
      wr(REG_DES_CNT, 32'(d));
      wr(REG_CTRL, (r == 0) ? 32'h0 : 32'h4);
      for (int k = 1; k <= s + 2; k++) begin
        term.pulses((r == 0) ? 1 : 2, 1, (r == 0) ? 3 : 1);
        repeat (3) @(posedge ref_clk);
        chk(desCntReached, k >= d, "designated flag");
        chk(setCntReached, k >= s, "set flag");
        rdchk(REG_COUNT, (k > s) ? 32'(s) : 32'(k), "count");
      end
      term.clear(1'h0);
      repeat (3) @(posedge ref_clk);
      rdchk(REG_FLAGS, 32'h0, "flags cleared");
      rdchk(REG_COUNT, 32'h0, "count cleared");
    end
    done("count");
    tally_and_finish();
  end
endmodule // swing_length_count_tb
